// [hdl/ccr_defs.vh]
// Constants for the charge-flow control register block
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// Register address and reset value
`define CCR_ADDR_CHARGE_FLOW_CONTROL 8'h0E
`define CCR_RESET_CHARGE_FLOW_CONTROL 8'h1C

// Field positions
`define CCR_BIT_CONTINUE_AFTER_TIMEOUT 7
`define CCR_BIT_RESERVED_HI 6
`define CCR_BIT_RECHARGE_DISABLE 5
`define CCR_BIT_BATTERY_ABSENCE_RETEST 4
`define CCR_BIT_TERMINATION_ENABLE 3
`define CCR_BIT_TOP_OFF_ENABLE 2
`define CCR_BIT_HIGH_IMPEDANCE_REQUEST 1
`define CCR_BIT_RESERVED_LO 0

// Mask of bits that software can write
`define CCR_WRITABLE_MASK 8'hBE

// Timing
`define CCR_CORE_CLK_HZ 25000000
`define CCR_RETEST_PERIOD_S 2
`define CCR_RETEST_CYCLES (`CCR_RETEST_PERIOD_S * `CCR_CORE_CLK_HZ)
`define CCR_RETEST_CNT_W 26

`endif

// [hdl/ccr_retest_timer.v]
// Periodic tick generator for the battery absence retest
`timescale 1ns/10ps
`default_nettype none
`include "ccr_defs.vh"

module ccr_retest_timer #(
  parameter RETEST_CYCLES = `CCR_RETEST_CYCLES
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire run_i,
  output reg  tick_o
);

  // Terminal count, cut to the counter width on purpose
  localparam integer                 LAST_FULL = RETEST_CYCLES - 1;
  localparam [`CCR_RETEST_CNT_W-1:0] LAST      = LAST_FULL[`CCR_RETEST_CNT_W-1:0];

  reg [`CCR_RETEST_CNT_W-1:0] count_reg;

  // ----------------------------------------
  // Free count while running, restart when stopped
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      count_reg <= {`CCR_RETEST_CNT_W{1'b0}};
      tick_o    <= 1'b0;
    end
    else if (count_reg == LAST)
    begin
      count_reg <= {`CCR_RETEST_CNT_W{1'b0}};
      tick_o    <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 1'b1;
      tick_o    <= 1'b0;
    end
  end

endmodule // ccr_retest_timer

`default_nettype wire

// [hdl/ccr_charge_flow.v]
// Charge-flow control register and its charge state sequencing
//
// Overview of operation
// R1: Continue bit set: a safety timer expiry is ignored, charging goes on.
// R2: Every safety timer expiry still raises timeout status and timer interrupt; here only while charging (charge or done state).
// R3: Continue bit clear: expiry resets all registers but the safety register.
// R4: Continue bit clear: expiry drops the charger into idle.
// R5: The continue bit leaves the watchdog untouched.
// R6: Recharge below float minus offset with termination on, unless recharge disabled.
// R7: Retest bit clear: no battery found means no further absence test.
// R8: Retest bit set: absence test repeats every two seconds until battery appears.
// R9: Without battery the buck runs and the battery FET is off.
// R10: Termination bit set ends charge below termination current; clear keeps charging.
// R11: Top-off charging only while top-off enable is set.
// R12: High-impedance request bit puts the device into high impedance.
// R13: Boost enable overrides high impedance; it returns when boost drops.
// R14: High-impedance request clears when battery is under minimum threshold.
// R15: Writes to high-impedance request are dropped while battery under minimum.
// R16: Bits 6 and 0 read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "ccr_defs.vh"

module ccr_charge_flow #(
  parameter RETEST_CYCLES = `CCR_RETEST_CYCLES
) (
  input  wire       CORE_CLK_I,
  input  wire       RST_I,
  input  wire [7:0] REG_ADDR_I,
  input  wire       REG_WR_I,
  input  wire [7:0] REG_WDATA_I,
  output reg  [7:0] REG_RDATA_O,
  input  wire       CHARGE_START_I,
  input  wire       SAFETY_EXPIRE_I,
  input  wire       WATCHDOG_EXPIRE_I,
  input  wire       BOOST_ENABLE_I,
  input  wire       BAT_UNDER_MIN_I,
  input  wire       BAT_UNDER_RECHARGE_I,
  input  wire       IBAT_UNDER_TERM_I,
  input  wire       BAT_PRESENT_I,
  output wire       CHARGE_ON_O,
  output wire       TOP_OFF_ON_O,
  output wire       BUCK_ON_O,
  output wire       BATTERY_FET_ON_O,
  output wire       HIGH_Z_O,
  output reg        ABSENCE_TEST_O,
  output reg        TIMER_TIMEOUT_STATUS_SET_O,
  output reg        TIMER_IRQ_SET_O,
  output reg        REG_DEFAULTS_O,
  output reg        WATCHDOG_DEFAULTS_O,
  output wire [3:0] STATE_O
);

  // One-hot charger states
  localparam [3:0] ST_IDLE   = 4'h1;
  localparam [3:0] ST_CHARGE = 4'h2;
  localparam [3:0] ST_DONE   = 4'h4;
  localparam [3:0] ST_NOBAT  = 4'h8;

  // Address match, used by both write and read paths
  function addr_hit;
    input [7:0] addr;
    begin
      addr_hit = (addr == `CCR_ADDR_CHARGE_FLOW_CONTROL);
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [3:0] pin_raw;
  wire [3:0] pin_sync;

  assign pin_raw = {BAT_PRESENT_I, IBAT_UNDER_TERM_I, BAT_UNDER_RECHARGE_I, BAT_UNDER_MIN_I};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_sync
      // Private stages, so each flop has a single driver
      reg stage1_reg;
      reg stage2_reg;

      // Two flops per comparator pin
      always @(posedge CORE_CLK_I)
      begin
        if (RST_I)
        begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end
        else
        begin
          stage1_reg <= pin_raw[g];
          stage2_reg <= stage1_reg;
        end
      end

      assign pin_sync[g] = stage2_reg;
    end
  endgenerate

  wire bat_under_min      = pin_sync[0];
  wire bat_under_recharge = pin_sync[1];
  wire ibat_under_term    = pin_sync[2];
  wire bat_present        = pin_sync[3];

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  reg  [7:0] ctrl_reg;
  reg  [7:0] ctrl_next;
  reg  [3:0] state_reg;
  reg  [3:0] state_next;
  wire       wr_hit = REG_WR_I && addr_hit(REG_ADDR_I);
  wire       continue_after_timeout_en     = ctrl_reg[`CCR_BIT_CONTINUE_AFTER_TIMEOUT];
  wire       rchg_dis    = ctrl_reg[`CCR_BIT_RECHARGE_DISABLE];
  wire       retest_en   = ctrl_reg[`CCR_BIT_BATTERY_ABSENCE_RETEST];
  wire       term_en     = ctrl_reg[`CCR_BIT_TERMINATION_ENABLE];
  wire       topoff_en   = ctrl_reg[`CCR_BIT_TOP_OFF_ENABLE];
  wire       hz_request  = ctrl_reg[`CCR_BIT_HIGH_IMPEDANCE_REQUEST];
  wire       charging    = (state_reg == ST_CHARGE) || (state_reg == ST_DONE);
  wire       timeout_stop = charging && SAFETY_EXPIRE_I && !continue_after_timeout_en;        // R1 R3
  wire       retest_tick;

  // Next register value
  always @*
  begin
    ctrl_next = ctrl_reg;
    if (timeout_stop)
      ctrl_next = `CCR_RESET_CHARGE_FLOW_CONTROL;                           // R3
    else
    begin
      if (wr_hit)
      begin
        ctrl_next = (ctrl_reg & ~`CCR_WRITABLE_MASK)
                  | (REG_WDATA_I & `CCR_WRITABLE_MASK);                    // R16
        if (bat_under_min)
          ctrl_next[`CCR_BIT_HIGH_IMPEDANCE_REQUEST] = hz_request;          // R15
      end
      if (bat_under_min)
        ctrl_next[`CCR_BIT_HIGH_IMPEDANCE_REQUEST] = 1'b0;                 // R14
    end
    ctrl_next[`CCR_BIT_RESERVED_HI] = 1'b0;                                // R16
    ctrl_next[`CCR_BIT_RESERVED_LO] = 1'b0;                                // R16
  end

  // Register storage
  always @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      ctrl_reg <= `CCR_RESET_CHARGE_FLOW_CONTROL;
    else
      ctrl_reg <= ctrl_next;
  end

  // Read data
  always @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      REG_RDATA_O <= 8'h00;
    else if (addr_hit(REG_ADDR_I))
      REG_RDATA_O <= ctrl_reg;                                              // R16
    else
      REG_RDATA_O <= 8'h00;
  end

  // ----------------------------------------
  // Charger state sequencing
  // ----------------------------------------
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (CHARGE_START_I)
          state_next = bat_present ? ST_CHARGE : ST_NOBAT;
      end
      ST_CHARGE:
      begin
        if (timeout_stop)
          state_next = ST_IDLE;                                             // R4
        else if (!bat_present)
          state_next = ST_NOBAT;
        else if (term_en && ibat_under_term)
          state_next = ST_DONE;                                             // R10
      end
      ST_DONE:
      begin
        if (timeout_stop)
          state_next = ST_IDLE;                                             // R4
        else if (!bat_present)
          state_next = ST_NOBAT;
        else if (term_en && !rchg_dis && bat_under_recharge)
          state_next = ST_CHARGE;                                           // R6
      end
      ST_NOBAT:
      begin
        if (retest_en && retest_tick && bat_present)
          state_next = ST_CHARGE;                                           // R8
        else if (CHARGE_START_I && bat_present)
          state_next = ST_CHARGE;                                           // R7
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // State register
  always @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------
  // Retest pacing
  // ----------------------------------------
  ccr_retest_timer #(
    .RETEST_CYCLES (RETEST_CYCLES)
  ) u_retest (
    .clk_i  (CORE_CLK_I),
    .rst_i  (RST_I),
    .run_i  ((state_reg == ST_NOBAT) && retest_en),                         // R7
    .tick_o (retest_tick)
  );

  // ----------------------------------------
  // Event outputs
  // ----------------------------------------
  always @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      ABSENCE_TEST_O             <= 1'b0;
      TIMER_TIMEOUT_STATUS_SET_O <= 1'b0;
      TIMER_IRQ_SET_O            <= 1'b0;
      REG_DEFAULTS_O             <= 1'b0;
      WATCHDOG_DEFAULTS_O        <= 1'b0;
    end
    else
    begin
      // Test at plug-in, at end of charge, and on each retest tick
      ABSENCE_TEST_O             <= CHARGE_START_I
                                 || ((state_reg == ST_CHARGE) && (state_next == ST_DONE))
                                 || ((state_reg == ST_NOBAT) && retest_en && retest_tick); // R8
      TIMER_TIMEOUT_STATUS_SET_O <= charging && SAFETY_EXPIRE_I;            // R2
      TIMER_IRQ_SET_O            <= charging && SAFETY_EXPIRE_I;            // R2
      REG_DEFAULTS_O             <= timeout_stop;                           // R3
      WATCHDOG_DEFAULTS_O        <= WATCHDOG_EXPIRE_I;                      // R5
    end
  end

  // ----------------------------------------
  // Power path controls
  // ----------------------------------------
  assign CHARGE_ON_O      = charging && !(state_reg == ST_DONE && !topoff_en); // R1
  assign TOP_OFF_ON_O     = (state_reg == ST_DONE) && topoff_en;              // R11
  assign BUCK_ON_O        = !HIGH_Z_O;                                        // R9
  assign BATTERY_FET_ON_O = (state_reg != ST_NOBAT);                          // R9
  assign HIGH_Z_O         = hz_request && !BOOST_ENABLE_I;                    // R12 R13
  assign STATE_O          = state_reg;

endmodule // ccr_charge_flow

`default_nettype wire

// [test/ccr_charge_flow_asserts.sv]
// Port-level property checker for the charge-flow register block
`timescale 1ns/10ps
`default_nettype none
module ccr_charge_flow_asserts (
  input wire logic       CORE_CLK_I, RST_I, CHARGE_START_I, SAFETY_EXPIRE_I, WATCHDOG_EXPIRE_I,
  input wire logic       BOOST_ENABLE_I, BAT_UNDER_MIN_I, BUCK_ON_O, BATTERY_FET_ON_O, HIGH_Z_O,
  input wire logic       ABSENCE_TEST_O, TIMER_TIMEOUT_STATUS_SET_O, TIMER_IRQ_SET_O,
  input wire logic       REG_DEFAULTS_O, WATCHDOG_DEFAULTS_O, TOP_OFF_ON_O,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic [3:0] STATE_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // Expiry while charging, start request in idle
  sequence s_expire;
    SAFETY_EXPIRE_I && (STATE_O[1] || STATE_O[2]);
  endsequence
  sequence s_start;
    CHARGE_START_I && STATE_O[0];
  endsequence
  // Port relations
  AST_EXP_FLAGS: assert property (s_expire |=> TIMER_IRQ_SET_O && TIMER_TIMEOUT_STATUS_SET_O) else $error("flags");
  AST_DEFAULTS: assert property (REG_DEFAULTS_O |-> TIMER_IRQ_SET_O && STATE_O == 4'h1) else $error("dflt");
  AST_WDOG: assert property (WATCHDOG_EXPIRE_I |=> WATCHDOG_DEFAULTS_O) else $error("wdog");
  AST_START: assert property (s_start |=> ABSENCE_TEST_O) else $error("no test");
  AST_NOBAT: assert property (STATE_O[3] |-> !BATTERY_FET_ON_O) else $error("fet on");
  AST_HZ_BUCK: assert property (BUCK_ON_O == !HIGH_Z_O) else $error("buck");
  AST_BOOST: assert property (BOOST_ENABLE_I |-> !HIGH_Z_O) else $error("boost");
  AST_MIN: assert property (BAT_UNDER_MIN_I [*4] |=> !HIGH_Z_O) else $error("min");
  AST_RSVD: assert property (REG_RDATA_O[6] == 1'h0 && REG_RDATA_O[0] == 1'h0) else $error("rsvd");
  AST_CONTINUE_AFTER_TIMEOUT: assert property (s_expire |=> REG_DEFAULTS_O || STATE_O != 4'h1) else $error("continue_after_timeout");
  AST_TOPOFF: assert property (TOP_OFF_ON_O |-> STATE_O == 4'h4) else $error("topoff");
endmodule // ccr_charge_flow_asserts
bind ccr_charge_flow ccr_charge_flow_asserts u_asserts (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .CHARGE_START_I(CHARGE_START_I),
  .SAFETY_EXPIRE_I(SAFETY_EXPIRE_I), .WATCHDOG_EXPIRE_I(WATCHDOG_EXPIRE_I),
  .BOOST_ENABLE_I(BOOST_ENABLE_I), .BAT_UNDER_MIN_I(BAT_UNDER_MIN_I), .BUCK_ON_O(BUCK_ON_O),
  .BATTERY_FET_ON_O(BATTERY_FET_ON_O), .HIGH_Z_O(HIGH_Z_O), .ABSENCE_TEST_O(ABSENCE_TEST_O),
  .TIMER_TIMEOUT_STATUS_SET_O(TIMER_TIMEOUT_STATUS_SET_O), .TIMER_IRQ_SET_O(TIMER_IRQ_SET_O),
  .REG_DEFAULTS_O(REG_DEFAULTS_O), .WATCHDOG_DEFAULTS_O(WATCHDOG_DEFAULTS_O), .TOP_OFF_ON_O(TOP_OFF_ON_O),
  .REG_RDATA_O(REG_RDATA_O), .STATE_O(STATE_O));
`default_nettype wire

// [test/ccr_host_model.sv]
// Host model driving the register access port
`timescale 1ns/10ps
`default_nettype none
module ccr_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic       wr_o,
  output var  logic [7:0] addr_o,
  output var  logic [7:0] wdata_o
);
  initial {wr_o, addr_o, wdata_o} = 17'h0;
  // Write strobe held one edge, data scrambled after
  task put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {addr_o, wr_o, wdata_o} <= {a, 1'h1, d};
    @(posedge clk_i);
    {wr_o, wdata_o} <= {1'h0, ~d};
    #1;
  endtask
  // Read data is registered one edge after the address
  task get(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_i);
    addr_o <= a;
    repeat (2) @(posedge clk_i);
    #1 q = rdata_i;
  endtask
endmodule // ccr_host_model
`default_nettype wire

// [test/tb_ccr_charge_flow.sv]
// Self-checking bench for the charge-flow register block
`timescale 1ns/10ps
`default_nettype none
module tb_ccr_charge_flow;
  localparam RT = 20;
  logic       clk = 0, rst = 1, start = 0, sexp = 0, wexp = 0, boost = 0;
  logic       umin = 0, urch = 0, uterm = 0, pres = 1, wr;
  logic [7:0] addr, wdata, rdata, q;
  wire        chg, top, buck, fet, hz, abs, tmo, irq, rdef, wdef;
  wire  [3:0] st;
  integer     failures = 0, num_checks = 0, seed = 27283, m = 'h1C, i;
  always #20 clk = ~clk;
  ccr_host_model u_ccr_host_model (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
  ccr_charge_flow #(.RETEST_CYCLES(RT)) u_ccr_charge_flow (.CORE_CLK_I(clk), .RST_I(rst),
    .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .CHARGE_START_I(start), .SAFETY_EXPIRE_I(sexp), .WATCHDOG_EXPIRE_I(wexp),
    .BOOST_ENABLE_I(boost), .BAT_UNDER_MIN_I(umin), .BAT_UNDER_RECHARGE_I(urch),
    .IBAT_UNDER_TERM_I(uterm), .BAT_PRESENT_I(pres), .CHARGE_ON_O(chg), .TOP_OFF_ON_O(top),
    .BUCK_ON_O(buck), .BATTERY_FET_ON_O(fet), .HIGH_Z_O(hz), .ABSENCE_TEST_O(abs),
    .TIMER_TIMEOUT_STATUS_SET_O(tmo), .TIMER_IRQ_SET_O(irq), .REG_DEFAULTS_O(rdef),
    .WATCHDOG_DEFAULTS_O(wdef), .STATE_O(st));
  // Helpers: compare, wait, register model, pulses
  task chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task w(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task put(input logic [7:0] d);
    u_ccr_host_model.put(8'h0E, d);
    m = d & (umin ? 8'hBC : 8'hBE);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    u_ccr_host_model.get(a, q);
    chk(q, e);
  endtask
  task pls(input integer k);
    @(posedge clk);
    {start, sexp, wexp} <= 3'h4 >> k;
    @(posedge clk);
    {start, sexp, wexp} <= 3'h0;
    #1;
  endtask
  task complete_run;
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 0;
    w(3);
    rd(8'h0E, 8'h1C);
    for (i = 0; i < 6; i++)
    begin
      put(8'($random(seed)));
      rd(8'h0E, 8'(m));
    end
    u_ccr_host_model.put(8'h0F, 8'hFF);
    rd(8'h0F, 8'h00);
    put(8'h1E);
    chk({hz, buck}, 2'h2);
    @(posedge clk) boost <= 1;
    #1 chk(hz, 1'h0);
    @(posedge clk) boost <= 0;
    #1 chk(hz, 1'h1);
    @(posedge clk) umin <= 1;
    w(4);
    chk(hz, 1'h0);
    put(8'h1E);
    rd(8'h0E, 8'h1C);
    @(posedge clk) umin <= 0;
    pls(0);
    chk({st, abs}, 5'h05);
    @(posedge clk) uterm <= 1;
    w(4);
    chk({st, top, chg}, 6'h13);
    put(8'h18);
    chk({top, chg}, 2'h0);
    @(posedge clk) {urch, uterm} <= 2'h2;
    w(4);
    chk(st, 4'h2);
    @(posedge clk) {urch, uterm} <= 2'h1;
    w(4);
    put(8'h38);
    @(posedge clk) {urch, uterm} <= 2'h2;
    w(4);
    chk(st, 4'h4);
    pls(1);
    chk({st, irq, tmo, rdef}, 7'h0F);
    rd(8'h0E, 8'h1C);
    @(posedge clk) urch <= 0;
    pls(0);
    put(8'h10);
    @(posedge clk) uterm <= 1;
    w(4);
    chk(st, 4'h2);
    put(8'h90);
    pls(1);
    chk({st, irq, rdef}, 6'h0A);
    pls(2);
    chk({st, wdef}, 5'h05);
    @(posedge clk) pres <= 0;
    w(4);
    chk({st, fet, buck}, 6'h21);
    @(posedge clk) pres <= 1;
    w(RT - 2);
    chk(st, 4'h8);
    w(1);
    chk({st, abs}, 5'h05);
    put(8'h80);
    @(posedge clk) pres <= 0;
    w(4);
    @(posedge clk) pres <= 1;
    w(3 * RT);
    chk(st, 4'h8);
    complete_run;
  end
  // Watchdog against a hang
  initial
  begin
    #100000;
    failures++;
    complete_run;
  end
endmodule // tb_ccr_charge_flow
`default_nettype wire
